// >>> asq_chk.sv
`timescale 1ns/1ns
module asq_chk
    import asq_pkg::*;
#(
    parameter int N_FEAT = 8,
    parameter int FEAT_W = 16,
    parameter int FIDX_W = 3
)(
    input wire logic                          sys_clk,
    input wire logic                          rst_n,
    input wire logic                          set_config_phase,
    input wire logic                          set_run_phase,
    input wire logic                          streaming,
    input wire logic [SET_IDX_W-1:0]          set_index_pick,
    input wire logic                          set_recall_cmd,
    input wire logic                          feat_wr,
    input wire logic [FIDX_W-1:0]             feat_wr_sel,
    input wire logic [FEAT_W-1:0]             feat_wr_data,
    input wire logic [N_FEAT-1:0]             auto_mask,
    input wire logic [N_FEAT-1:0][FEAT_W-1:0] feat_value,
    input wire logic [N_FEAT-1:0]             feat_lock,
    input wire logic                          wr_refused,
    input wire logic                          set_ok_flag,
    input wire logic [SET_IDX_W-1:0]          active_set_index,
    input wire logic                          sequencer_running
);
    // features holding a non-zero value
    logic [N_FEAT-1:0] nz;
    always_comb
    begin
        for (int i = 0; i < N_FEAT; i++)
            nz[i] = |feat_value[i];
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    // ------------------------------------------------------------
    // phase control
    // ------------------------------------------------------------
    stream_block_a: assert property (streaming && !sequencer_running |=> !sequencer_running)
        else $error("run began while streaming");
    cfg_norun_a: assert property (set_config_phase && !sequencer_running |=> !sequencer_running)
        else $error("run began during configuration");
    run_stop_a: assert property (sequencer_running && !set_run_phase |=> !sequencer_running)
        else $error("run did not stop");
    // scan may hold the exit for up to one pass over the sets
    cfg_exit_a: assert property ($fell(set_config_phase) && !sequencer_running |-> ##[1:12] feat_lock == '0)
        else $error("configuration exit did not unlock");

    // ------------------------------------------------------------
    // feature writes and locks
    // ------------------------------------------------------------
    wr_lock_a: assert property (feat_wr |=> wr_refused == $past(feat_lock[feat_wr_sel]))
        else $error("refusal does not match lock");
    wr_idle_a: assert property (!feat_wr |=> !wr_refused)
        else $error("refusal without a write");
    wr_apply_a: assert property (feat_wr && !feat_lock[feat_wr_sel] && !sequencer_running && !set_recall_cmd
        |=> feat_value[$past(feat_wr_sel)] == $past(feat_wr_data))
        else $error("unlocked write lost");
    forced_off_a: assert property (sequencer_running && $past(sequencer_running) |-> (nz & auto_mask & feat_lock) == '0)
        else $error("forced feature not off in run");

    // ------------------------------------------------------------
    // recall, flag lags the selector by one cycle
    // ------------------------------------------------------------
    recall_ok_a: assert property (set_recall_cmd && set_ok_flag && !sequencer_running && !set_config_phase
        && $stable(set_index_pick) && $past(set_index_pick, 2) == set_index_pick
        |=> active_set_index == $past(set_index_pick))
        else $error("valid set not loaded");
    recall_bad_a: assert property (set_recall_cmd && !set_ok_flag && !sequencer_running && !set_config_phase
        && $stable(set_index_pick) && $past(set_index_pick, 2) == set_index_pick
        |=> $stable(active_set_index))
        else $error("invalid set loaded");

    run_seen_c: cover property ($rose(sequencer_running));
    refuse_seen_c: cover property (wr_refused);
    exit_seen_c: cover property ($fell(set_config_phase) ##[1:12] feat_lock == '0);
endmodule // asq_chk

bind asq_sequencer asq_chk #(.N_FEAT(N_FEAT), .FEAT_W(FEAT_W), .FIDX_W(FIDX_W)) i_chk (
    .sys_clk, .rst_n, .set_config_phase, .set_run_phase, .streaming, .set_index_pick, .set_recall_cmd,
    .feat_wr, .feat_wr_sel, .feat_wr_data, .auto_mask, .feat_value, .feat_lock, .wr_refused, .set_ok_flag,
    .active_set_index, .sequencer_running);

// >>> asq_pkg.sv
package asq_pkg;

    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int SET_IDX_W  = 3;
    localparam int N_SETS_DEF = 8;
    localparam int N_FEAT_DEF = 8;
    localparam int FEAT_W_DEF = 16;
    localparam int SRC_W      = 2;
    localparam int N_SRC      = 4;

    // ------------------------------------------------------------
    // reset and forced values
    // ------------------------------------------------------------
    localparam logic [SET_IDX_W-1:0] SET_IDX_RST   = 3'h0;
    localparam logic [SRC_W-1:0]     SRC_RST       = 2'h0;
    localparam logic                 FLAG_RST      = 1'h0;
    localparam logic [FEAT_W_DEF-1:0] FORCED_OFF   = 16'h0000;

    // ------------------------------------------------------------
    // enumerations
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ASQ_PH_OFF = 2'h0,
        ASQ_PH_CFG = 2'h1,
        ASQ_PH_RUN = 2'h2
    } asq_phase_t;

    typedef enum logic [1:0] {
        ASQ_EDGE_RISE = 2'h0,
        ASQ_EDGE_FALL = 2'h1,
        ASQ_EDGE_ANY  = 2'h2,
        ASQ_EDGE_HIGH = 2'h3
    } asq_edge_t;

    typedef enum logic {
        ASQ_SCAN_IDLE = 1'h0,
        ASQ_SCAN_BUSY = 1'h1
    } asq_scan_t;

endpackage

// >>> asq_sequencer.sv
`timescale 1ns/1ns
module asq_sequencer
    import asq_pkg::*;
#(
    parameter int N_FEAT = N_FEAT_DEF,
    parameter int FEAT_W = FEAT_W_DEF,
    parameter int N_SETS = N_SETS_DEF,
    parameter int FIDX_W = $clog2(N_FEAT)
)(
    input  wire logic                          sys_clk,
    input  wire logic                          rst_n,
    input  wire logic                          seq_feature_wr,
    input  wire logic [FIDX_W-1:0]             seq_feature_pick,
    input  wire logic                          seq_feature_on,
    input  wire logic                          set_config_phase,
    input  wire logic                          set_run_phase,
    input  wire logic                          streaming,
    input  wire logic [SET_IDX_W-1:0]          set_index_pick,
    input  wire logic                          set_store_cmd,
    input  wire logic                          set_recall_cmd,
    input  wire logic [SET_IDX_W-1:0]          first_set_index,
    input  wire logic                          path_wr,
    input  wire logic [SRC_W-1:0]              step_event_source,
    input  wire logic [1:0]                    step_event_edge,
    input  wire logic [SET_IDX_W-1:0]          following_set_index,
    input  wire logic [N_SRC-1:0]              step_events,
    input  wire logic                          feat_wr,
    input  wire logic [FIDX_W-1:0]             feat_wr_sel,
    input  wire logic [FEAT_W-1:0]             feat_wr_data,
    input  wire logic [N_FEAT-1:0][N_FEAT-1:0] dep_map,
    input  wire logic [N_FEAT-1:0]             auto_mask,
    output logic      [N_FEAT-1:0][FEAT_W-1:0] feat_value,
    output logic      [N_FEAT-1:0]             feat_lock,
    output logic                               wr_refused,
    output logic                               set_ok_flag,
    output logic                               whole_config_ok_flag,
    output logic      [SET_IDX_W-1:0]          active_set_index,
    output logic                               sequencer_running
);
    localparam logic [SET_IDX_W-1:0] LAST_SET = SET_IDX_W'(N_SETS - 1);

    asq_store_if #(.N_FEAT(N_FEAT), .FEAT_W(FEAT_W), .N_SETS(N_SETS)) st ();

    asq_phase_t                  phase_r;
    asq_phase_t                  phase_nxt;
    logic                        cfg_prev_r;
    logic                        run_prev_r;
    logic [N_SRC-1:0]            ev_prev_r;
    logic [N_FEAT-1:0]           feature_on_r;
    logic [N_FEAT-1:0]           dir_r;
    logic [N_FEAT-1:0]           imp_r;
    logic [N_FEAT-1:0]           fix_r;
    logic [N_FEAT-1:0]           frc_r;
    logic [N_FEAT-1:0]           imp_c;
    logic [N_FEAT-1:0]           fix_c;
    logic [N_FEAT-1:0]           frc_c;
    logic [N_FEAT-1:0]           clo_c;
    logic [N_FEAT-1:0]           lock_nxt;
    logic [SRC_W-1:0]            path_src_r  [N_SETS];
    asq_edge_t                   path_edge_r [N_SETS];
    logic [SET_IDX_W-1:0]        path_next_r [N_SETS];
    logic                        run_start;
    logic                        hit;
    logic                        step;
    logic                        recall_ok;
    logic                        load_go;
    logic                        wr_ok;
    logic                        cfg_ok;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic set_exists(input logic [SET_IDX_W-1:0] i);
        return i <= LAST_SET;
    endfunction

    // features that the given features rely on
    function automatic logic [N_FEAT-1:0] precond_of(input logic [N_FEAT-1:0] m,
                                                     input logic [N_FEAT-1:0][N_FEAT-1:0] dm);
        logic [N_FEAT-1:0] r;
        r = '0;
        for (int i = 0; i < N_FEAT; i++)
            if (m[i])
                r = r | dm[i];
        return r;
    endfunction

    // ------------------------------------------------------------
    // feature classes
    // ------------------------------------------------------------
    // preconditions are closed transitively so a chain of ranges stays legal
    always_comb
    begin
        imp_c = '0;
        for (int i = 0; i < N_FEAT; i++)
            imp_c[i] = |(dep_map[i] & feature_on_r);
        imp_c = imp_c & ~feature_on_r;
        clo_c = feature_on_r | imp_c;
        for (int k = 0; k < N_FEAT; k++)
            clo_c = clo_c | precond_of(clo_c, dep_map);
        fix_c = clo_c & ~(feature_on_r | imp_c) & ~auto_mask;
        frc_c = clo_c & ~(feature_on_r | imp_c) & auto_mask;
    end

    // enables are only taken outside configuration and run
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            feature_on_r <= '0;
        else if (seq_feature_wr && phase_r == ASQ_PH_OFF)
            feature_on_r[seq_feature_pick] <= seq_feature_on;
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            dir_r <= '0;
            imp_r <= '0;
            fix_r <= '0;
            frc_r <= '0;
        end
        else if (phase_r == ASQ_PH_OFF && phase_nxt == ASQ_PH_CFG)
        begin
            dir_r <= feature_on_r;
            imp_r <= imp_c;
            fix_r <= fix_c;
            frc_r <= frc_c;
        end
    end

    // ------------------------------------------------------------
    // phase control
    // ------------------------------------------------------------
    always_comb
    begin
        unique case (path_edge_r[active_set_index])
            ASQ_EDGE_RISE: hit = step_events[path_src_r[active_set_index]]
                               & ~ev_prev_r[path_src_r[active_set_index]];
            ASQ_EDGE_FALL: hit = ~step_events[path_src_r[active_set_index]]
                               & ev_prev_r[path_src_r[active_set_index]];
            ASQ_EDGE_ANY:  hit = step_events[path_src_r[active_set_index]]
                               ^ ev_prev_r[path_src_r[active_set_index]];
            ASQ_EDGE_HIGH: hit = step_events[path_src_r[active_set_index]];
        endcase
    end

    assign run_start = (phase_r == ASQ_PH_OFF) && set_run_phase && !run_prev_r
                       && whole_config_ok_flag && !streaming && !set_config_phase;
    assign step      = (phase_r == ASQ_PH_RUN) && hit
                       && st.valid[path_next_r[active_set_index]];
    assign recall_ok = set_recall_cmd && set_exists(set_index_pick)
                       && st.valid[set_index_pick] && !step;
    assign load_go   = run_start || step || recall_ok;

    always_comb
    begin
        phase_nxt = phase_r;
        unique case (phase_r)
            ASQ_PH_OFF:
                if (set_config_phase && !cfg_prev_r)
                    phase_nxt = ASQ_PH_CFG;
                else if (run_start)
                    phase_nxt = ASQ_PH_RUN;
            // exit waits for the validity scan so the final check is current
            ASQ_PH_CFG:
                if (!set_config_phase && !st.busy)
                    phase_nxt = ASQ_PH_OFF;
            ASQ_PH_RUN:
                if (!set_run_phase)
                    phase_nxt = ASQ_PH_OFF;
            default: phase_nxt = ASQ_PH_OFF;
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            phase_r    <= ASQ_PH_OFF;
            cfg_prev_r <= FLAG_RST;
            run_prev_r <= FLAG_RST;
            ev_prev_r  <= '0;
        end
        else
        begin
            phase_r    <= phase_nxt;
            cfg_prev_r <= set_config_phase;
            run_prev_r <= set_run_phase;
            ev_prev_r  <= step_events;
        end
    end

    // ------------------------------------------------------------
    // transition paths
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            for (int s = 0; s < N_SETS; s++)
            begin
                path_src_r[s]  <= SRC_RST;
                path_edge_r[s] <= ASQ_EDGE_RISE;
                path_next_r[s] <= SET_IDX_RST;
            end
        end
        else if (path_wr && phase_r == ASQ_PH_CFG && set_exists(set_index_pick)
                 && set_exists(following_set_index))
        begin
            path_src_r[set_index_pick]  <= step_event_source;
            path_edge_r[set_index_pick] <= asq_edge_t'(step_event_edge);
            path_next_r[set_index_pick] <= following_set_index;
        end
    end

    // start set and the next set of every valid set must hold valid contents
    always_comb
    begin
        cfg_ok = st.valid[first_set_index] && set_exists(first_set_index);
        for (int s = 0; s < N_SETS; s++)
            if (st.valid[s] && !st.valid[path_next_r[s]])
                cfg_ok = 1'b0;
    end

    // ------------------------------------------------------------
    // store control
    // ------------------------------------------------------------
    assign st.store     = set_store_cmd && phase_r == ASQ_PH_CFG && set_exists(set_index_pick);
    assign st.store_idx = set_index_pick;
    assign st.snap_val  = feat_value;
    assign st.snap_mask = dir_r | imp_r | fix_r | frc_r;
    assign st.fix_mask  = fix_r;
    assign st.rd_idx    = step      ? path_next_r[active_set_index] :
                          run_start ? first_set_index : set_index_pick;

    asq_set_store #(
        .N_FEAT (N_FEAT),
        .FEAT_W (FEAT_W),
        .N_SETS (N_SETS)
    ) u_store (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .st      (st)
    );

    // ------------------------------------------------------------
    // locks and feature values
    // ------------------------------------------------------------
    always_comb
    begin
        unique case (phase_nxt)
            ASQ_PH_CFG: lock_nxt = fix_r;
            ASQ_PH_RUN: lock_nxt = dir_r | imp_r | fix_r | frc_r;
            default:    lock_nxt = '0;
        endcase
    end

    assign wr_ok = feat_wr && !feat_lock[feat_wr_sel];

    // non-sequenced features carry no stored mask bit and so never load
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            feat_value <= '0;
        else
        begin
            for (int f = 0; f < N_FEAT; f++)
            begin
                if (load_go && st.rd_mask[f])
                    feat_value[f] <= st.rd_val[f];
                else if (wr_ok && feat_wr_sel == FIDX_W'(f))
                    feat_value[f] <= feat_wr_data;
                if (phase_nxt == ASQ_PH_RUN && frc_r[f])
                    feat_value[f] <= FEAT_W'(FORCED_OFF);
            end
        end
    end

    // ------------------------------------------------------------
    // status outputs
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            feat_lock            <= '0;
            wr_refused           <= FLAG_RST;
            set_ok_flag          <= FLAG_RST;
            whole_config_ok_flag <= FLAG_RST;
            active_set_index     <= SET_IDX_RST;
            sequencer_running    <= FLAG_RST;
        end
        else
        begin
            feat_lock         <= lock_nxt;
            wr_refused        <= feat_wr && feat_lock[feat_wr_sel];
            set_ok_flag       <= set_exists(set_index_pick) && st.valid[set_index_pick];
            sequencer_running <= (phase_nxt == ASQ_PH_RUN);
            if (phase_r == ASQ_PH_OFF && phase_nxt == ASQ_PH_CFG)
                whole_config_ok_flag <= 1'b0;
            else if (phase_r == ASQ_PH_CFG && phase_nxt == ASQ_PH_OFF)
                whole_config_ok_flag <= cfg_ok;
            if (load_go)
                active_set_index <= st.rd_idx;
        end
    end

endmodule // asq_sequencer

// >>> asq_set_store.sv
`timescale 1ns/1ns
module asq_set_store
    import asq_pkg::*;
#(
    parameter int N_FEAT = N_FEAT_DEF,
    parameter int FEAT_W = FEAT_W_DEF,
    parameter int N_SETS = N_SETS_DEF
)(
    input  wire logic   sys_clk,
    input  wire logic   rst_n,
    asq_store_if.mem    st
);
    localparam logic [SET_IDX_W-1:0] LAST_SET = SET_IDX_W'(N_SETS - 1);

    logic [N_FEAT-1:0][FEAT_W-1:0] val_mem  [N_SETS];
    logic [N_FEAT-1:0]             mask_mem [N_SETS];
    logic [N_SETS-1:0]             written_r;
    logic [N_SETS-1:0]             valid_r;
    logic [SET_IDX_W-1:0]          ptr_r;
    asq_scan_t                     scan_r;
    logic                          match;

    // ------------------------------------------------------------
    // set storage
    // ------------------------------------------------------------
    // every feature value is kept, sequenced or not, so dependents ride along
    always_ff @(posedge sys_clk)
    begin
        if (st.store)
        begin
            val_mem[st.store_idx]  <= st.snap_val;
            mask_mem[st.store_idx] <= st.snap_mask;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            written_r <= '0;
        else if (st.store)
            written_r[st.store_idx] <= 1'b1;
    end

    // guarded read: an absent set reads as empty rather than unknown
    assign st.rd_val  = (st.rd_idx <= LAST_SET) ? val_mem[st.rd_idx]  : '0;
    assign st.rd_mask = (st.rd_idx <= LAST_SET) ? mask_mem[st.rd_idx] : '0;

    // ------------------------------------------------------------
    // validity scan
    // ------------------------------------------------------------
    // a scan keeps a set valid only if its class map and fixed values match now
    always_comb
    begin
        match = written_r[ptr_r] && (mask_mem[ptr_r] == st.snap_mask);
        for (int f = 0; f < N_FEAT; f++)
            if (st.fix_mask[f] && (val_mem[ptr_r][f] != st.snap_val[f]))
                match = 1'b0;
    end

    // one set per cycle keeps the comparator small; a new save restarts it
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            valid_r <= '0;
            ptr_r   <= SET_IDX_RST;
            scan_r  <= ASQ_SCAN_IDLE;
        end
        else if (st.store)
        begin
            valid_r[st.store_idx] <= 1'b0;
            ptr_r  <= SET_IDX_RST;
            scan_r <= ASQ_SCAN_BUSY;
        end
        else
        begin
            unique case (scan_r)
                ASQ_SCAN_IDLE: ;
                ASQ_SCAN_BUSY:
                begin
                    valid_r[ptr_r] <= match;
                    ptr_r <= ptr_r + 3'h1;
                    if (ptr_r == LAST_SET)
                        scan_r <= ASQ_SCAN_IDLE;
                end
            endcase
        end
    end

    assign st.valid = valid_r;
    assign st.busy  = (scan_r == ASQ_SCAN_BUSY);

endmodule // asq_set_store

// >>> asq_store_if.sv
`timescale 1ns/1ns
interface asq_store_if
    import asq_pkg::*;
#(
    parameter int N_FEAT = N_FEAT_DEF,
    parameter int FEAT_W = FEAT_W_DEF,
    parameter int N_SETS = N_SETS_DEF
);
    logic                             store;
    logic [SET_IDX_W-1:0]             store_idx;
    logic [SET_IDX_W-1:0]             rd_idx;
    logic [N_FEAT-1:0][FEAT_W-1:0]    snap_val;
    logic [N_FEAT-1:0]                snap_mask;
    logic [N_FEAT-1:0]                fix_mask;
    logic [N_FEAT-1:0][FEAT_W-1:0]    rd_val;
    logic [N_FEAT-1:0]                rd_mask;
    logic [N_SETS-1:0]                valid;
    logic                             busy;

    modport seq (output store, store_idx, rd_idx, snap_val, snap_mask, fix_mask,
                 input  rd_val, rd_mask, valid, busy);
    modport mem (input  store, store_idx, rd_idx, snap_val, snap_mask, fix_mask,
                 output rd_val, rd_mask, valid, busy);
endinterface

// >>> tb_top.sv
`timescale 1ns/1ns
module tb_top;
    import asq_pkg::*;
    localparam int NS = 6;
    localparam int K_OK = 0, K_IDX = 1, K_REF = 2, K_CFG = 3, K_RUN = 4, K_LOCK = 5, K_VAL = 6;
    typedef struct {int kind; int sel; logic [15:0] exp;} asq_note_t;

    logic             sys_clk = 1'b0, rst_n = 1'b0, seq_feature_wr = 1'b0, seq_feature_on = 1'b0;
    logic             set_config_phase = 1'b0, set_run_phase = 1'b0, streaming = 1'b0, feat_wr = 1'b0;
    logic             set_store_cmd = 1'b0, set_recall_cmd = 1'b0, path_wr = 1'b0;
    logic [2:0]       seq_feature_pick = 3'h0, set_index_pick = 3'h0, first_set_index = 3'h0;
    logic [2:0]       following_set_index = 3'h0, feat_wr_sel = 3'h0;
    logic [1:0]       step_event_source = 2'h0, step_event_edge = 2'h0;
    logic [3:0]       step_events = 4'h0;
    logic [15:0]      feat_wr_data = 16'h0000, a, b;
    logic [15:0]      v [2];
    logic [7:0][7:0]  dep_map = '0;
    logic [7:0]       auto_mask = 8'h08, feat_lock;
    logic [7:0][15:0] feat_value;
    logic             wr_refused, set_ok_flag, whole_config_ok_flag, sequencer_running;
    logic [2:0]       active_set_index;
    int               bad_count = 0, cmp_count = 0;
    asq_note_t        notes[$];
    asq_note_t        nt;
    event             look;
    string            kname[7] = '{"set_ok_flag", "active_set_index", "wr_refused", "whole_config_ok_flag",
                                   "sequencer_running", "feat_lock", "feat_value"};

    always #5 sys_clk = ~sys_clk;

    asq_sequencer #(.N_SETS(NS)) i_dut (
        .sys_clk, .rst_n, .seq_feature_wr, .seq_feature_pick, .seq_feature_on, .set_config_phase,
        .set_run_phase, .streaming, .set_index_pick, .set_store_cmd, .set_recall_cmd, .first_set_index,
        .path_wr, .step_event_source, .step_event_edge, .following_set_index, .step_events, .feat_wr,
        .feat_wr_sel, .feat_wr_data, .dep_map, .auto_mask, .feat_value, .feat_lock, .wr_refused,
        .set_ok_flag, .whole_config_ok_flag, .active_set_index, .sequencer_running);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic pulse(ref logic s);
        s = 1'b1;
        tick(1);
        s = 1'b0;
    endtask

    task automatic note(input int k, input int s, input logic [15:0] e);
        notes.push_back('{k, s, e});
        ->look;
        #0;
    endtask

    // write a feature and note whether the lock must refuse it
    task automatic fwr(input logic [2:0] s, input logic [15:0] d, input logic refused);
        feat_wr = 1'b1;
        feat_wr_sel = s;
        feat_wr_data = d;
        tick(1);
        feat_wr = 1'b0;
        note(K_REF, 0, {15'h0, refused});
    endtask

    task automatic save(input logic [2:0] i, input logic ok);
        set_index_pick = i;
        pulse(set_store_cmd);
        tick(NS + 2);
        note(K_OK, 0, {15'h0, ok});
    endtask

    task automatic recall(input logic [2:0] i, input logic [2:0] e);
        set_index_pick = i;
        tick(2);
        pulse(set_recall_cmd);
        tick(1);
        note(K_IDX, 0, {13'h0, e});
    endtask

    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // leave configuration; exit scan length varies, so poll the lock under a bound
    task automatic wait_unlock();
        int i;
        set_config_phase = 1'b0;
        for (i = 0; i < 20 && feat_lock !== 8'h00; i++)
            tick(1);
        if (i == 20)
        begin
            bad_count++;
            test_done();
        end
    endtask

    function automatic logic [15:0] seen_of(input asq_note_t n);
        case (n.kind)
            K_OK:    return {15'h0, set_ok_flag};
            K_IDX:   return {13'h0, active_set_index};
            K_REF:   return {15'h0, wr_refused};
            K_CFG:   return {15'h0, whole_config_ok_flag};
            K_RUN:   return {15'h0, sequencer_running};
            K_LOCK:  return {8'h0, feat_lock};
            default: return feat_value[n.sel];
        endcase
    endfunction

    // monitor: oldest note against what the outputs show now
    always @(look)
    begin
        while (notes.size() > 0)
        begin
            nt = notes.pop_front();
            check(kname[nt.kind], seen_of(nt), nt.exp);
        end
    end

    // ------------------------------------------------------------
    // main sequence: 0 direct, 1 fixed, 2 implied, 4 untouched
    // ------------------------------------------------------------
    initial
    begin
        void'($urandom(32'hCCA5A031));
        v[0] = 16'($urandom);
        v[1] = 16'($urandom);
        a = 16'($urandom);
        b = 16'($urandom);
        dep_map[0] = 8'h02;
        dep_map[2] = 8'h09;
        tick(4);
        rst_n = 1'b1;
        fwr(3'h1, a, 1'b0);
        fwr(3'h3, b | 16'h0001, 1'b0);
        fwr(3'h4, b, 1'b0);
        seq_feature_on = 1'b1;
        pulse(seq_feature_wr);
        set_config_phase = 1'b1;
        tick(2);
        note(K_LOCK, 0, 16'h0002);
        fwr(3'h1, ~a, 1'b1);
        note(K_VAL, 1, a);
        for (int s = 0; s < 2; s++)
        begin
            fwr(3'h0, v[s], 1'b0);
            fwr(3'h2, v[s] ^ 16'h5A5A, 1'b0);
            save(3'(s), 1'b1);
            following_set_index = 3'(s ^ 1);
            pulse(path_wr);
        end
        save(3'h7, 1'b0);
        wait_unlock();
        tick(1);
        note(K_CFG, 0, 16'h0001);
        recall(3'h1, 3'h1);
        note(K_VAL, 0, v[1]);
        note(K_VAL, 2, v[1] ^ 16'h5A5A);
        recall(3'h7, 3'h1);
        streaming = 1'b1;
        set_run_phase = 1'b1;
        tick(2);
        note(K_RUN, 0, 16'h0000);
        set_run_phase = 1'b0;
        streaming = 1'b0;
        tick(1);
        set_run_phase = 1'b1;
        tick(3);
        note(K_RUN, 0, 16'h0001);
        note(K_IDX, 0, 16'h0000);
        note(K_VAL, 0, v[0]);
        note(K_VAL, 3, 16'h0000);
        fwr(3'h0, ~v[0], 1'b1);
        fwr(3'h2, ~v[0], 1'b1);
        fwr(3'h4, ~b, 1'b0);
        note(K_VAL, 4, ~b);
        step_events[0] = 1'b1;
        tick(3);
        note(K_IDX, 0, 16'h0001);
        note(K_VAL, 0, v[1]);
        step_events = 4'(16'($urandom) & 16'h000E);
        tick(2);
        step_events[0] = 1'b1;
        tick(3);
        note(K_IDX, 0, 16'h0000);
        set_run_phase = 1'b0;
        tick(2);
        note(K_RUN, 0, 16'h0000);
        note(K_VAL, 0, v[0]);
        fwr(3'h1, a ^ 16'h0F0F, 1'b0);
        set_config_phase = 1'b1;
        tick(2);
        save(3'h2, 1'b1);
        set_index_pick = 3'h0;
        tick(3);
        note(K_OK, 0, 16'h0000);
        wait_unlock();
        tick(2);
        note(K_CFG, 0, 16'h0000);
        tick(1);
        test_done();
    end
endmodule // tb_top
